// >>> rtl/pmec_top.v
// Performance monitor error counter bank: pattern bit errors, transmit
// slips and excessive zero violations, with interrupt status and mask.
// Assumes event strobes and the register port are synchronous to CLK_I.
//
// Functional notes
// RULE1: Keep a 16-bit count of receive pattern checker bit errors.
// RULE2: Pattern low byte register returns count bits 7 down to 0.
// RULE3: Every counter register clears on host read, then counts from zero.
// RULE4: Host reads the upper byte before the lower byte for a correct count.
// RULE5: Host clears a 16-bit counter by reading upper then lower byte.
// RULE6: Keep an 8-bit transmit slip count, one per slip.
// RULE7: Slip count accumulates since its last read and clears on read.
// RULE8: A slip is a whole frame repeated or dropped by the slip buffer.
// RULE9: Keep a 16-bit count of receive excessive zero violations.
// RULE10: Zero violation high byte is bits 15..8, low byte bits 7..0.
// RULE11: Pattern high byte register returns bits 15..8 and clears on read.
// RULE12: Upper byte read snapshots lower byte and clears the whole counter.
// RULE13: Counters reset to zero and saturate at their maximum.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "pmec_defs.vh"

module pmec_top (
    input  wire                 CLK_I,
    input  wire                 RST_I,
    input  wire [`PMEC_AW-1:0]  ADDR_I,
    input  wire [`PMEC_DW-1:0]  WDATA_I,
    input  wire                 WR_I,
    input  wire                 RD_I,
    output wire [`PMEC_DW-1:0]  RDATA_O,
    input  wire                 PATTERN_ERR_I,
    input  wire                 ZERO_VIOL_I,
    input  wire                 TX_SLIP_REPEAT_I,
    input  wire                 TX_SLIP_DROP_I,
    output wire                 IRQ_O
);

    // Address decode.
    wire hit_pat_high;
    wire hit_pat_low;
    wire hit_slip;
    wire hit_zero_high;
    wire hit_zero_low;
    wire hit_irq_stat;
    wire hit_irq_mask;

    assign hit_pat_high  = (ADDR_I == `PMEC_ADDR_PAT_HIGH);
    assign hit_pat_low   = (ADDR_I == `PMEC_ADDR_PAT_LOW);
    assign hit_slip      = (ADDR_I == `PMEC_ADDR_SLIP);
    assign hit_zero_high = (ADDR_I == `PMEC_ADDR_ZERO_HIGH);
    assign hit_zero_low  = (ADDR_I == `PMEC_ADDR_ZERO_LOW);
    assign hit_irq_stat  = (ADDR_I == `PMEC_ADDR_IRQ_STAT);
    assign hit_irq_mask  = (ADDR_I == `PMEC_ADDR_IRQ_MASK);

    // Read strobes that clear counters or their lower byte snapshots.
    wire rd_pat_high;
    wire rd_pat_low;
    wire rd_slip;
    wire rd_zero_high;
    wire rd_zero_low;

    assign rd_pat_high  = RD_I & hit_pat_high;
    assign rd_pat_low   = RD_I & hit_pat_low;
    assign rd_slip      = RD_I & hit_slip;
    assign rd_zero_high = RD_I & hit_zero_high;
    assign rd_zero_low  = RD_I & hit_zero_low;

    // Either a repeated or a dropped frame is one slip.
    wire slip_event;

    assign slip_event = TX_SLIP_REPEAT_I | TX_SLIP_DROP_I; // [RULE8]

    // Counter instances.
    wire [15:0] pat_count;
    wire [7:0]  pat_low_snap;
    wire        pat_sat;
    wire [7:0]  slip_count;
    wire        slip_sat;
    wire [15:0] zero_count;
    wire [7:0]  zero_low_snap;
    wire        zero_sat;

    pmec_wide_counter u_pattern_counter (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .event_i    (PATTERN_ERR_I),
        .rd_high_i  (rd_pat_high),
        .rd_low_i   (rd_pat_low),
        .count_o    (pat_count),
        .low_snap_o (pat_low_snap),
        .sat_o      (pat_sat)
    );

    pmec_byte_counter u_slip_counter (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .event_i (slip_event),
        .rd_i    (rd_slip),
        .count_o (slip_count),
        .sat_o   (slip_sat)
    );

    pmec_wide_counter u_zero_counter (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .event_i    (ZERO_VIOL_I),
        .rd_high_i  (rd_zero_high),
        .rd_low_i   (rd_zero_low),
        .count_o    (zero_count),
        .low_snap_o (zero_low_snap),
        .sat_o      (zero_sat)
    );

    // Interrupt event vector; the saturation bit flags an event lost to a full counter.
    wire [`PMEC_IRQ_N-1:0] irq_event;

    assign irq_event[`PMEC_IRQ_PAT]  = PATTERN_ERR_I;
    assign irq_event[`PMEC_IRQ_SLIP] = slip_event;
    assign irq_event[`PMEC_IRQ_ZERO] = ZERO_VIOL_I;
    assign irq_event[`PMEC_IRQ_SAT]  = (PATTERN_ERR_I & pat_sat & ~rd_pat_high)
                                     | (slip_event & slip_sat & ~rd_slip)
                                     | (ZERO_VIOL_I & zero_sat & ~rd_zero_high); // [RULE13]

    // Interrupt status, mask and output.
    wire                   wr_irq_stat;
    wire                   wr_irq_mask;
    reg  [`PMEC_IRQ_N-1:0] irq_stat_reg;
    reg  [`PMEC_IRQ_N-1:0] irq_mask_reg;
    reg                    irq_reg;

    assign wr_irq_stat = WR_I & hit_irq_stat;
    assign wr_irq_mask = WR_I & hit_irq_mask;

    // Sticky bits: a one written clears, a new event in the same cycle wins.
    genvar gi;
    generate
        for (gi = 0; gi < `PMEC_IRQ_N; gi = gi + 1) begin : g_irq_bit
            always @(posedge CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    irq_stat_reg[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_stat_reg[gi] <= 1'b1;
                end else if (wr_irq_stat && WDATA_I[gi]) begin
                    irq_stat_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_mask_reg <= `PMEC_IRQ_ZERO_VAL;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= WDATA_I[`PMEC_IRQ_N-1:0];
        end
    end

    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign IRQ_O = irq_reg;

    // Read data mux, sampled before the same edge clears the counter.
    reg [`PMEC_DW-1:0] rd_mux;

    always @* begin
        rd_mux = `PMEC_BYTE_ZERO;
        if (hit_pat_high) begin
            rd_mux = pat_count[`PMEC_HI_MSB:`PMEC_HI_LSB]; // [RULE11]
        end else if (hit_pat_low) begin
            rd_mux = pat_low_snap; // [RULE2] [RULE4]
        end else if (hit_slip) begin
            rd_mux = slip_count; // [RULE7]
        end else if (hit_zero_high) begin
            rd_mux = zero_count[`PMEC_HI_MSB:`PMEC_HI_LSB]; // [RULE10]
        end else if (hit_zero_low) begin
            rd_mux = zero_low_snap; // [RULE10] [RULE4] [RULE5]
        end else if (hit_irq_stat) begin
            rd_mux = {`PMEC_IRQ_PAD, irq_stat_reg};
        end else if (hit_irq_mask) begin
            rd_mux = {`PMEC_IRQ_PAD, irq_mask_reg};
        end
    end

    // Read data stands only in the cycle after the read strobe.
    reg [`PMEC_DW-1:0] rdata_reg;

    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_reg <= `PMEC_BYTE_ZERO;
        end else if (RD_I) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= `PMEC_BYTE_ZERO;
        end
    end

    assign RDATA_O = rdata_reg;

endmodule // pmec_top

`default_nettype wire

// >>> rtl/pmec_defs.vh
// Constants for the performance monitor error counter bank.
// Assumes inclusion by every design file of the bank, once per file.
`ifndef PMEC_DEFS_VH
`define PMEC_DEFS_VH

// Register bus widths.
`define PMEC_AW              16
`define PMEC_DW              8

// Register byte offsets.
`define PMEC_ADDR_PAT_HIGH   16'h090E
`define PMEC_ADDR_PAT_LOW    16'h090F
`define PMEC_ADDR_SLIP       16'h0910
`define PMEC_ADDR_ZERO_HIGH  16'h0911
`define PMEC_ADDR_ZERO_LOW   16'h0912
`define PMEC_ADDR_IRQ_STAT   16'h0920
`define PMEC_ADDR_IRQ_MASK   16'h0921

// Counter limits and reset values.
`define PMEC_CNT16_ZERO      16'h0000
`define PMEC_CNT16_ONE       16'h0001
`define PMEC_CNT16_MAX       16'hFFFF
`define PMEC_CNT8_ZERO       8'h00
`define PMEC_CNT8_ONE        8'h01
`define PMEC_CNT8_MAX        8'hFF
`define PMEC_BYTE_ZERO       8'h00

// Byte fields of a sixteen-bit count.
`define PMEC_HI_MSB          15
`define PMEC_HI_LSB          8
`define PMEC_LO_MSB          7
`define PMEC_LO_LSB          0

// Interrupt status and mask layout.
`define PMEC_IRQ_N           4
`define PMEC_IRQ_PAT         0
`define PMEC_IRQ_SLIP        1
`define PMEC_IRQ_ZERO        2
`define PMEC_IRQ_SAT         3
`define PMEC_IRQ_ZERO_VAL    4'h0
`define PMEC_IRQ_PAD         4'h0

`endif

// >>> rtl/pmec_wide_counter.v
// Sixteen-bit clear-on-read event counter with a lower byte snapshot.
// Assumes one-cycle event and read strobes synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pmec_defs.vh"

module pmec_wide_counter (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        event_i,
    input  wire        rd_high_i,
    input  wire        rd_low_i,
    output wire [15:0] count_o,
    output wire [7:0]  low_snap_o,
    output wire        sat_o
);

    reg [15:0] count_reg;
    reg [7:0]  snap_reg;

    assign count_o    = count_reg;
    assign low_snap_o = snap_reg;
    assign sat_o      = (count_reg == `PMEC_CNT16_MAX);

    // An event in the cycle of the clearing read starts the new interval at one.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= `PMEC_CNT16_ZERO; // [RULE13]
            snap_reg  <= `PMEC_BYTE_ZERO;
        end else begin
            if (rd_high_i) begin
                count_reg <= event_i ? `PMEC_CNT16_ONE : `PMEC_CNT16_ZERO; // [RULE3] [RULE12]
            end else if (event_i && !sat_o) begin
                count_reg <= count_reg + `PMEC_CNT16_ONE; // [RULE1] [RULE9] [RULE13]
            end
            if (rd_high_i) begin
                snap_reg <= count_reg[`PMEC_LO_MSB:`PMEC_LO_LSB]; // [RULE12]
            end else if (rd_low_i) begin
                snap_reg <= `PMEC_BYTE_ZERO; // [RULE3]
            end
        end
    end

endmodule // pmec_wide_counter

`default_nettype wire

// >>> rtl/pmec_byte_counter.v
// Eight-bit clear-on-read event counter.
// Assumes one-cycle event and read strobes synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pmec_defs.vh"

module pmec_byte_counter (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       event_i,
    input  wire       rd_i,
    output wire [7:0] count_o,
    output wire       sat_o
);

    reg [7:0] count_reg;

    assign count_o = count_reg;
    assign sat_o   = (count_reg == `PMEC_CNT8_MAX);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= `PMEC_CNT8_ZERO; // [RULE13]
        end else if (rd_i) begin
            count_reg <= event_i ? `PMEC_CNT8_ONE : `PMEC_CNT8_ZERO; // [RULE7] [RULE3]
        end else if (event_i && !sat_o) begin
            count_reg <= count_reg + `PMEC_CNT8_ONE; // [RULE6] [RULE13]
        end
    end

endmodule // pmec_byte_counter

`default_nettype wire

// >>> test/pmec_top_monitor.sv
// Checker for the error counter bank, watching the top module's ports only.
// Assumes one clock, CLK_I, and the asynchronous reset RST_I.
`timescale 1ns/1ps
`default_nettype none
`include "pmec_defs.vh"

module pmec_top_monitor (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [7:0]  RDATA_O,
    input wire logic        PATTERN_ERR_I,
    input wire logic        ZERO_VIOL_I,
    input wire logic        TX_SLIP_REPEAT_I,
    input wire logic        TX_SLIP_DROP_I,
    input wire logic        IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire slip  = TX_SLIP_REPEAT_I | TX_SLIP_DROP_I;
    wire rd_ph = RD_I && ADDR_I == `PMEC_ADDR_PAT_HIGH;
    wire rd_pl = RD_I && ADDR_I == `PMEC_ADDR_PAT_LOW;
    wire rd_zh = RD_I && ADDR_I == `PMEC_ADDR_ZERO_HIGH;
    wire rd_zl = RD_I && ADDR_I == `PMEC_ADDR_ZERO_LOW;
    wire rd_sl = RD_I && ADDR_I == `PMEC_ADDR_SLIP;

    // One event between two upper reads must come back whole in the lower byte.
    property p_one(h, l, e);
        h && !e ##1 e && !RD_I ##1 h ##1 l |-> RDATA_O == 8'h00 ##1 RDATA_O == 8'h01;
    endproperty
    property p_clr(h, e);
        h && !e ##1 h |=> RDATA_O == 8'h00;
    endproperty

    chk_reset_quiet: assert property ($fell(RST_I) |-> RDATA_O == 8'h00 && !IRQ_O)
        else $error("outputs not quiet after reset");
    chk_read_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data outside the read answer cycle");
    chk_pat_one: assert property (p_one(rd_ph, rd_pl, PATTERN_ERR_I))
        else $error("pattern count bytes wrong");
    chk_zero_one: assert property (p_one(rd_zh, rd_zl, ZERO_VIOL_I))
        else $error("zero violation count bytes wrong");
    chk_pat_clear: assert property (p_clr(rd_ph, PATTERN_ERR_I))
        else $error("pattern count not cleared by read");
    chk_zero_clear: assert property (p_clr(rd_zh, ZERO_VIOL_I))
        else $error("zero violation count not cleared by read");
    chk_slip_clear: assert property (p_clr(rd_sl, slip))
        else $error("slip count not cleared by read");
    chk_slip_one: assert property (rd_sl && !slip ##1 slip && !RD_I ##1 rd_sl |=> RDATA_O == 8'h01)
        else $error("single slip not counted once");

    cover property (rd_ph ##1 rd_pl);
    cover property (rd_zh ##1 rd_zl);
    cover property ($rose(IRQ_O));
endmodule // pmec_top_monitor
`default_nettype wire

// >>> test/test_pmec_top.sv
// Self-checking testbench for the error counter bank top.
// Assumes the design files and pmec_defs.vh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pmec_defs.vh"

module test_pmec_top;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic [3:0]  ev = 4'h0;
    wire  [7:0]  rdata;
    wire         irq;
    int          err_total = 0, checks = 0;

    pmec_top i_pmec_top (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PATTERN_ERR_I(ev[0]), .ZERO_VIOL_I(ev[1]),
        .TX_SLIP_REPEAT_I(ev[2]), .TX_SLIP_DROP_I(ev[3]), .IRQ_O(irq));

    initial begin
        forever #20 clk = ~clk;
    end

    task step(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d,
              input logic [3:0] e);
        @(posedge clk);
        rd <= r; wr <= w; addr <= a; wdata <= d; ev <= e;
    endtask
    task rq(input logic [15:0] a); step(1'b1, 1'b0, a, 8'h00, 4'h0); endtask
    task wq(input logic [15:0] a, input logic [7:0] d); step(1'b0, 1'b1, a, d, 4'h0); endtask
    task evt(input logic [3:0] e); step(1'b0, 1'b0, 16'h0000, 8'h00, e); endtask
    task cmp8(input string n, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Read data is compared just after the edge that follows the read cycle.
    task see(input string n, input logic [7:0] exp); #1 cmp8(n, exp, rdata); endtask

    task t_reset;
        logic [15:0] a [7];
        a = '{`PMEC_ADDR_PAT_HIGH, `PMEC_ADDR_PAT_LOW, `PMEC_ADDR_SLIP, `PMEC_ADDR_ZERO_HIGH,
              `PMEC_ADDR_ZERO_LOW, `PMEC_ADDR_IRQ_STAT, `PMEC_ADDR_IRQ_MASK};
        for (int i = 0; i < 7; i++) begin
            rq(a[i]);
            evt(4'h0);
            see("reset value", 8'h00);
        end
        cmp8("irq after reset", 8'h00, {7'h00, irq});
    endtask

    task t_wide(input logic [15:0] h, input logic [15:0] l, input logic [3:0] e);
        rq(h);
        rq(l);
        rq(h);
        evt(e);
        rq(h);
        rq(l);
        see("upper after one", 8'h00);
        evt(4'h0);
        see("lower after one", 8'h01);
        repeat (291) evt(e);
        rq(h);
        rq(l);
        see("upper count", 8'h01);
        rq(h);
        see("lower count", 8'h23);
        rq(h);
        see("upper cleared", 8'h00);
        rq(l);
        see("upper cleared", 8'h00);
        evt(4'h0);
        see("lower cleared", 8'h00);
    endtask

    task t_slip;
        rq(`PMEC_ADDR_SLIP);
        evt(4'h4);
        rq(`PMEC_ADDR_SLIP);
        evt(4'h8);
        see("one repeat", 8'h01);
        evt(4'hC);
        rq(`PMEC_ADDR_SLIP);
        rq(`PMEC_ADDR_SLIP);
        see("drop and both", 8'h02);
        evt(4'h0);
        see("slip cleared", 8'h00);
        repeat (260) evt(4'h4);
        rq(`PMEC_ADDR_SLIP);
        evt(4'h0);
        see("slip saturated", 8'hFF);
    endtask

    task t_irq;
        rq(`PMEC_ADDR_IRQ_STAT);
        evt(4'h0);
        see("status", 8'h0F);
        cmp8("irq masked", 8'h00, {7'h00, irq});
        wq(`PMEC_ADDR_IRQ_MASK, 8'h02);
        rq(`PMEC_ADDR_IRQ_MASK);
        evt(4'h0);
        see("mask", 8'h02);
        cmp8("irq raised", 8'h01, {7'h00, irq});
        wq(`PMEC_ADDR_IRQ_STAT, 8'h02);
        evt(4'h0);
        rq(`PMEC_ADDR_IRQ_STAT);
        #1 cmp8("irq cleared", 8'h00, {7'h00, irq});
        evt(4'h4);
        see("status after clear", 8'h0D);
        wq(`PMEC_ADDR_PAT_HIGH, 8'hFF);
        rq(`PMEC_ADDR_PAT_HIGH);
        rq(16'h0000);
        see("counter write ignored", 8'h00);
        evt(4'h0);
        see("unmapped", 8'h00);
        cmp8("irq on slip", 8'h01, {7'h00, irq});
    endtask

    task complete_run;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_wide(`PMEC_ADDR_PAT_HIGH, `PMEC_ADDR_PAT_LOW, 4'h1);
        t_wide(`PMEC_ADDR_ZERO_HIGH, `PMEC_ADDR_ZERO_LOW, 4'h2);
        t_slip();
        t_irq();
        complete_run();
    end
endmodule // test_pmec_top

bind pmec_top pmec_top_monitor i_pmec_top_monitor (.CLK_I(CLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .PATTERN_ERR_I(PATTERN_ERR_I), .ZERO_VIOL_I(ZERO_VIOL_I),
    .TX_SLIP_REPEAT_I(TX_SLIP_REPEAT_I), .TX_SLIP_DROP_I(TX_SLIP_DROP_I), .IRQ_O(IRQ_O));
`default_nettype wire
